// >>> core/ldc_regs.sv
/*
  register bank of the two-channel led buck driver: target current,
  range, hysteresis, undervoltage threshold, supply readback and
  overcurrent off timing per channel.
  assumes a frame decoder delivering one-cycle register requests,
  an analog front end strobing supply codes, synchronous inputs.
*/
// Notes on behaviour
// - supply sampled into readable code, zero means none
// - supply code scale 0.3548 V, offset -0.56 V
// - writes to supply reading ignored, no error
// - flag high above threshold, low below
// - writable 8-bit undervoltage threshold, same scale
// - range bit per channel, 300/120 mV
// - range zero: 1.179 mV per step +0.74
// - range one: 0.47882 mV per step -0.6
// - per-channel two-bit hysteresis, upper bits reserved
// - hysteresis independent of range bits
// - new hysteresis and target applied while running
// - overcurrent stops gate, off 16 ms, restart
// - below threshold: all outputs and gate supply off
module ldc_regs #(
  parameter int OC_OFF_CYCLES = ldc_pkg::OC_OFF_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register access from frame decoder
  input wire ldc_pkg::ldc_reg_req_t i_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_err,
  // analog front end
  input wire logic i_adc_valid,
  input wire logic [7:0] i_supply_voltage_code,
  input wire logic [1:0] i_oc_detect,
  // dimming
  input wire logic i_dimming_input_ch1,
  input wire logic i_dimming_input_ch2,
  input wire logic [1:0] i_dim_enable,
  // converter controls
  output ldc_pkg::ldc_chan_cfg_t [1:0] o_chan_cfg,
  output logic [1:0] o_gate_enable,
  output logic o_gate_supply_enable,
  output logic o_supply_above_threshold_flag
);

  localparam int CW = $clog2(OC_OFF_CYCLES + 1);
  localparam logic [CW-1:0] OC_LOAD = CW'(OC_OFF_CYCLES);

  // an off count below one would never hold the gate off
  if (OC_OFF_CYCLES < 1) begin : g_bad_count
    $error("overcurrent off count must be at least one");
  end

  typedef struct packed {
    logic [1:0][7:0] tgt;
    logic [1:0] rng;
    logic [1:0][1:0] hys;
    logic [7:0] uv_thr;
    logic [7:0] supply_input_pin;
    logic [7:0] rdata;
    logic err;
    logic [1:0][CW-1:0] oc_cnt;
  } ldc_state_t;

  ldc_state_t s_q;
  ldc_state_t s_d;
  logic flag;
  logic [1:0] dim_in;
  logic mapped;

  // equal counts as above so a zero threshold never trips
  assign flag = (s_q.supply_input_pin >= s_q.uv_thr);
  assign dim_in = {i_dimming_input_ch2, i_dimming_input_ch1};

  always_comb begin
    unique case (i_req.addr)
      ldc_pkg::ADDR_TARGET_CH1, ldc_pkg::ADDR_TARGET_CH2, ldc_pkg::ADDR_RANGE,
      ldc_pkg::ADDR_HYST_CH1, ldc_pkg::ADDR_HYST_CH2, ldc_pkg::ADDR_UV_THRESH,
      ldc_pkg::ADDR_SUPPLY_READ: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.err = 1'b0;
    if (i_adc_valid) begin
      s_d.supply_input_pin = i_supply_voltage_code;
    end
    if (i_req.wr) begin
      s_d.err = !mapped;
      unique case (i_req.addr)
        ldc_pkg::ADDR_TARGET_CH1: s_d.tgt[0] = i_req.wdata;
        ldc_pkg::ADDR_TARGET_CH2: s_d.tgt[1] = i_req.wdata;
        ldc_pkg::ADDR_RANGE: begin
          s_d.rng[0] = i_req.wdata[ldc_pkg::RANGE_CH1_BIT];
          s_d.rng[1] = i_req.wdata[ldc_pkg::RANGE_CH2_BIT];
        end
        ldc_pkg::ADDR_HYST_CH1: begin
          s_d.hys[0] = i_req.wdata[ldc_pkg::HYST_MSB:ldc_pkg::HYST_LSB];
        end
        ldc_pkg::ADDR_HYST_CH2: begin
          s_d.hys[1] = i_req.wdata[ldc_pkg::HYST_MSB:ldc_pkg::HYST_LSB];
        end
        ldc_pkg::ADDR_UV_THRESH: s_d.uv_thr = i_req.wdata;
        default: ; // supply reading is read-only, dropped silently
      endcase
    end else if (i_req.rd) begin
      s_d.err = !mapped;
      unique case (i_req.addr)
        ldc_pkg::ADDR_TARGET_CH1: s_d.rdata = s_q.tgt[0];
        ldc_pkg::ADDR_TARGET_CH2: s_d.rdata = s_q.tgt[1];
        // reserved bits read as zero
        ldc_pkg::ADDR_RANGE: s_d.rdata = {6'h00, s_q.rng};
        ldc_pkg::ADDR_HYST_CH1: s_d.rdata = {6'h00, s_q.hys[0]};
        ldc_pkg::ADDR_HYST_CH2: s_d.rdata = {6'h00, s_q.hys[1]};
        ldc_pkg::ADDR_UV_THRESH: s_d.rdata = s_q.uv_thr;
        ldc_pkg::ADDR_SUPPLY_READ: s_d.rdata = s_q.supply_input_pin;
        default: s_d.rdata = 8'h00;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      // retrigger during the off time is ignored; only expiry restarts
      if (s_q.oc_cnt[c] != '0) begin
        s_d.oc_cnt[c] = s_q.oc_cnt[c] - CW'(1);
      end else if (i_oc_detect[c]) begin
        s_d.oc_cnt[c] = OC_LOAD;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.tgt <= {2{ldc_pkg::RST_TARGET}};
      s_q.rng <= ldc_pkg::RST_RANGE;
      s_q.hys <= {2{ldc_pkg::RST_HYST}};
      s_q.uv_thr <= ldc_pkg::RST_UV_THRESH;
      s_q.supply_input_pin <= ldc_pkg::SUPPLY_NOT_READY;
      s_q.rdata <= 8'h00;
      s_q.err <= 1'b0;
      s_q.oc_cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata = s_q.rdata;
  assign o_reg_err = s_q.err;
  assign o_supply_above_threshold_flag = flag;
  assign o_gate_supply_enable = flag;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    // range and hysteresis kept in separate fields
    assign o_chan_cfg[c].range_sel = s_q.rng[c];
    assign o_chan_cfg[c].hysteresis_sel = s_q.hys[c];
    assign o_chan_cfg[c].target_sense_code = s_q.tgt[c];
    // overcurrent kills the gate in the detect cycle itself
    assign o_gate_enable[c] = dim_in[c] && i_dim_enable[c] && flag
                              && !i_oc_detect[c] && (s_q.oc_cnt[c] == '0);
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_supply_capture: assert property (
    i_adc_valid |=> s_q.supply_input_pin == $past(i_supply_voltage_code))
    else $error("supply code not captured");

  a_readonly_write: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_SUPPLY_READ && !i_adc_valid
    |=> !o_reg_err && $stable(s_q.supply_input_pin))
    else $error("write to supply reading took effect");

  a_flag_compare: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_UV_THRESH && !i_adc_valid
    |=> o_supply_above_threshold_flag == (s_q.supply_input_pin >= $past(i_req.wdata)))
    else $error("supply flag wrong after threshold write");

  a_thresh_store: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_UV_THRESH
    ##1 !(i_req.wr && i_req.addr == ldc_pkg::ADDR_UV_THRESH)
    ##1 i_req.rd && !i_req.wr && i_req.addr == ldc_pkg::ADDR_UV_THRESH
    |=> o_reg_rdata == $past(i_req.wdata, 3))
    else $error("threshold readback mismatch");

  a_range_store: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_RANGE
    |=> {o_chan_cfg[1].range_sel, o_chan_cfg[0].range_sel} == $past(i_req.wdata[1:0]))
    else $error("range bits not stored");

  a_hyst_store: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_HYST_CH2
    |=> o_chan_cfg[1].hysteresis_sel == $past(i_req.wdata[1:0]))
    else $error("hysteresis not stored");

  a_range_keeps_hyst: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_RANGE
    |=> o_chan_cfg[0].hysteresis_sel == $past(o_chan_cfg[0].hysteresis_sel)
        && o_chan_cfg[1].hysteresis_sel == $past(o_chan_cfg[1].hysteresis_sel))
    else $error("range write altered hysteresis");

  a_target_live: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_TARGET_CH1
    |=> o_chan_cfg[0].target_sense_code == $past(i_req.wdata))
    else $error("target not applied");

  a_oc_load: assert property (
    i_oc_detect[0] && s_q.oc_cnt[0] == '0 |=> s_q.oc_cnt[0] == OC_LOAD ##1 !o_gate_enable[0])
    else $error("overcurrent off time not started");

  a_oc_stop: assert property (
    i_oc_detect[1] && s_q.oc_cnt[1] != CW'(1) |-> !o_gate_enable[1] ##1 !o_gate_enable[1])
    else $error("gate not stopped on overcurrent");

  a_uv_off: assert property (
    !o_supply_above_threshold_flag |-> o_gate_enable == 2'h0 && !o_gate_supply_enable)
    else $error("outputs active in undervoltage");

  // storage and independence of the config fields, supply flag and supply sample hold
  a_hyst_store_ch1: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_HYST_CH1
    |=> o_chan_cfg[0].hysteresis_sel == $past(i_req.wdata[1:0]))
    else $error("channel one hysteresis not stored");

  a_hyst_keeps_range: assert property (
    i_req.wr && (i_req.addr == ldc_pkg::ADDR_HYST_CH1 || i_req.addr == ldc_pkg::ADDR_HYST_CH2)
    |=> o_chan_cfg[0].range_sel == $past(o_chan_cfg[0].range_sel)
        && o_chan_cfg[1].range_sel == $past(o_chan_cfg[1].range_sel))
    else $error("hysteresis write altered range");

  a_target_live_ch2: assert property (
    i_req.wr && i_req.addr == ldc_pkg::ADDR_TARGET_CH2
    |=> o_chan_cfg[1].target_sense_code == $past(i_req.wdata))
    else $error("channel two target not applied");

  a_uv_zero: assert property (
    s_q.uv_thr == 8'h00 |-> o_supply_above_threshold_flag)
    else $error("zero threshold reported undervoltage");

  a_flag_supply: assert property (
    i_adc_valid && !(i_req.wr && i_req.addr == ldc_pkg::ADDR_UV_THRESH)
    |=> o_supply_above_threshold_flag == ($past(i_supply_voltage_code) >= s_q.uv_thr))
    else $error("supply flag wrong after new supply code");

  a_vin_hold: assert property (
    !i_adc_valid |=> $stable(s_q.supply_input_pin))
    else $error("supply code changed without a sample");

  // bus answer checks
  a_supply_read: assert property (
    i_req.rd && !i_req.wr && i_req.addr == ldc_pkg::ADDR_SUPPLY_READ
    |=> o_reg_rdata == $past(s_q.supply_input_pin))
    else $error("supply reading not returned");

  a_hyst_reserved: assert property (
    i_req.rd && !i_req.wr && i_req.addr == ldc_pkg::ADDR_HYST_CH1
    |=> o_reg_rdata[7:2] == 6'h00)
    else $error("reserved hysteresis bits read nonzero");

  a_range_reserved: assert property (
    i_req.rd && !i_req.wr && i_req.addr == ldc_pkg::ADDR_RANGE
    |=> o_reg_rdata[7:2] == 6'h00)
    else $error("reserved range bits read nonzero");

  a_rdata_hold: assert property (
    !i_req.rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  a_mapped_ok: assert property (
    (i_req.wr || i_req.rd) && mapped |=> !o_reg_err)
    else $error("error raised on a mapped register");

  a_err_idle: assert property (
    !i_req.wr && !i_req.rd |=> !o_reg_err)
    else $error("error raised without an access");

  a_unmapped_read: assert property (
    i_req.rd && !i_req.wr && !mapped |=> o_reg_err && o_reg_rdata == 8'h00)
    else $error("unmapped read not refused");

  // per-channel gate and off-count checks
  for (genvar c = 0; c < 2; c++) begin : g_oc_chk
    a_oc_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.oc_cnt[c] != '0 |-> !o_gate_enable[c])
      else $error("gate on during overcurrent off time");

    a_oc_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.oc_cnt[c] != '0 |=> s_q.oc_cnt[c] == $past(s_q.oc_cnt[c]) - CW'(1))
      else $error("overcurrent off count reloaded or stalled");

    a_gate_dim: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !dim_in[c] || !i_dim_enable[c] |-> !o_gate_enable[c])
      else $error("gate on without dimming input and enable");
  end

  // main scenarios
  c_oc_restart: cover property (s_q.oc_cnt[0] == CW'(1) ##1 o_gate_enable[0]);
  c_ch2_oc: cover property (i_oc_detect[1] && s_q.oc_cnt[1] == '0);
  c_uv_entry: cover property ($fell(o_supply_above_threshold_flag));
  c_readonly_write: cover property (i_req.wr && i_req.addr == ldc_pkg::ADDR_SUPPLY_READ);
  c_fade: cover property (o_gate_enable[0] && i_req.wr && i_req.addr == ldc_pkg::ADDR_TARGET_CH1);

endmodule : ldc_regs

// >>> core/ldc_pkg.sv
/*
  constants and carrier types for the led driver config register bank.
  assumes a 20 MHz system clock and an upstream serial frame decoder.
*/
package ldc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_TARGET_CH1 = 8'h02;
  localparam logic [7:0] ADDR_TARGET_CH2 = 8'h03;
  localparam logic [7:0] ADDR_RANGE = 8'h05;
  localparam logic [7:0] ADDR_HYST_CH1 = 8'h0B;
  localparam logic [7:0] ADDR_HYST_CH2 = 8'h0C;
  localparam logic [7:0] ADDR_UV_THRESH = 8'h0F;
  localparam logic [7:0] ADDR_SUPPLY_READ = 8'h38;

  // field positions
  localparam int RANGE_CH1_BIT = 0;
  localparam int RANGE_CH2_BIT = 1;
  localparam int HYST_LSB = 0;
  localparam int HYST_MSB = 1;

  // reset values
  localparam logic [7:0] RST_TARGET = 8'h00;
  localparam logic [1:0] RST_RANGE = 2'h0;
  localparam logic [1:0] RST_HYST = 2'h0;
  localparam logic [7:0] RST_UV_THRESH = 8'h00;
  localparam logic [7:0] SUPPLY_NOT_READY = 8'h00;

  // timing
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int OC_OFF_TIME_US = 16_000;
  localparam int OC_OFF_CYCLES = OC_OFF_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldc_reg_req_t;

  typedef struct packed {
    logic range_sel;
    logic [1:0] hysteresis_sel;
    logic [7:0] target_sense_code;
  } ldc_chan_cfg_t;

endpackage : ldc_pkg

// >>> sim/ldc_host_model.sv
/*
  host side model: issues single-byte register requests to the bank.
  assumes requests are taken on the rising edge of i_clk.
*/
module ldc_host_model (
  // clock
  input wire logic i_clk,
  // register request
  output ldc_pkg::ldc_reg_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_req = '0;
  end

  // request held over one rising edge, released at the next falling edge
  task automatic put(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(negedge i_clk);
    o_req = '0;
  endtask : put

  // target codes 00 and F6 and up are sent as 01 and F5 instead
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ldc_pkg::ADDR_RANGE || a == ldc_pkg::ADDR_HYST_CH1 ||
        a == ldc_pkg::ADDR_HYST_CH2) begin
      v = d & 8'h03;
    end
    if ((a == ldc_pkg::ADDR_TARGET_CH1 || a == ldc_pkg::ADDR_TARGET_CH2) &&
        (d == 8'h00 || d >= 8'hF6)) begin
      v = (d == 8'h00) ? 8'h01 : 8'hF5;
    end
    put(1'b1, a, v);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a);
    put(1'b0, a, 8'h00);
  endtask : read_reg
endmodule : ldc_host_model

// >>> sim/ldc_regs_tb.sv
/*
  self-checking bench for the register bank, driven through the host model.
  assumes off-count parameter shortened to 20 cycles.
*/
module ldc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OC_N = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic adc_valid = 1'b0;
  logic [7:0] supply_code = 8'h00;
  logic [1:0] oc = 2'h0;
  logic dim1 = 1'b0;
  logic dim2 = 1'b0;
  logic [1:0] dim_en = 2'h3;
  ldc_pkg::ldc_reg_req_t req;
  logic [7:0] rdata;
  logic reg_err;
  ldc_pkg::ldc_chan_cfg_t [1:0] cfg;
  logic [1:0] gate;
  logic gate_sup;
  logic flag;
  int err_total = 0;
  int n_tests = 0;
  int n;
  logic [7:0] addrs [6] = '{ldc_pkg::ADDR_TARGET_CH1, ldc_pkg::ADDR_TARGET_CH2,
    ldc_pkg::ADDR_RANGE, ldc_pkg::ADDR_HYST_CH1, ldc_pkg::ADDR_HYST_CH2,
    ldc_pkg::ADDR_UV_THRESH};
  logic [7:0] vals [6] = '{8'h32, 8'h7E, 8'h02, 8'h01, 8'h03, 8'h40};

  always #25 clk = ~clk;

  ldc_regs #(.OC_OFF_CYCLES(OC_N)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_reg_rdata(rdata), .o_reg_err(reg_err),
    .i_adc_valid(adc_valid), .i_supply_voltage_code(supply_code), .i_oc_detect(oc),
    .i_dimming_input_ch1(dim1), .i_dimming_input_ch2(dim2), .i_dim_enable(dim_en),
    .o_chan_cfg(cfg), .o_gate_enable(gate), .o_gate_supply_enable(gate_sup),
    .o_supply_above_threshold_flag(flag)
  );

  ldc_host_model u_host (.i_clk(clk), .o_req(req));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic e);
    u_host.read_reg(a);
    chk({7'h00, reg_err}, {7'h00, e});
    chk(rdata, exp);
  endtask : rd

  task automatic supply(input logic [7:0] c);
    @(negedge clk);
    adc_valid = 1'b1;
    supply_code = c;
    @(negedge clk);
    adc_valid = 1'b0;
  endtask : supply

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rd(ldc_pkg::ADDR_SUPPLY_READ, ldc_pkg::SUPPLY_NOT_READY, 1'b0);
    for (int i = 0; i < 6; i++) begin
      u_host.write_reg(addrs[i], vals[i]);
      rd(addrs[i], vals[i], 1'b0);
    end
    dim1 = 1'b1;
    dim2 = 1'b1;
    chk(cfg[0].target_sense_code, 8'h32);
    chk(cfg[1].target_sense_code, 8'h7E);
    chk({5'h00, cfg[1].range_sel, cfg[0].hysteresis_sel}, 8'h05);
    chk({6'h00, cfg[1].hysteresis_sel}, 8'h03);
    chk({4'h0, flag, gate_sup, gate}, 8'h00);
    supply(8'h80);
    rd(ldc_pkg::ADDR_SUPPLY_READ, 8'h80, 1'b0);
    chk({4'h0, flag, gate_sup, gate}, 8'h0F);
    u_host.write_reg(ldc_pkg::ADDR_SUPPLY_READ, 8'h11);
    chk({7'h00, reg_err}, 8'h00);
    rd(ldc_pkg::ADDR_SUPPLY_READ, 8'h80, 1'b0);
    rd(8'h10, 8'h00, 1'b1);
    u_host.write_reg(8'h10, 8'h55);
    chk({7'h00, reg_err}, 8'h01);
    u_host.write_reg(ldc_pkg::ADDR_RANGE, 8'h00);
    chk({2'h0, cfg[0].hysteresis_sel, cfg[1].hysteresis_sel, cfg[1].range_sel,
      cfg[0].range_sel}, 8'h1C);
    u_host.write_reg(ldc_pkg::ADDR_TARGET_CH1, 8'h20);
    chk({cfg[0].target_sense_code}, 8'h20);
    chk({6'h00, gate}, 8'h03);
    u_host.write_reg(ldc_pkg::ADDR_UV_THRESH, 8'h81);
    chk({6'h00, flag, gate_sup}, 8'h00);
    u_host.write_reg(ldc_pkg::ADDR_UV_THRESH, 8'h80);
    chk({6'h00, flag, gate_sup}, 8'h03);
    dim_en = 2'h2;
    #5;
    chk({6'h00, gate}, 8'h02);
    u_host.write_reg(ldc_pkg::ADDR_HYST_CH1, 8'h02);
    u_host.write_reg(ldc_pkg::ADDR_TARGET_CH1, 8'h40);
    dim_en = 2'h3;
    #5;
    chk({6'h00, cfg[0].hysteresis_sel}, 8'h02);
    chk(cfg[0].target_sense_code, 8'h40);
    chk({6'h00, gate}, 8'h03);
    // overcurrent on both channels, retrigger on channel 1 mid-count must not reload
    @(negedge clk);
    oc = 2'h3;
    #5;
    chk({6'h00, gate}, 8'h00);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (gate[0] === 1'b1) break;
      oc = (n == 5) ? 2'h1 : 2'h0;
    end while (n < 100);
    if (n >= 100) begin
      err_total++;
    end else begin
      chk(n[7:0], 8'(OC_N + 1));
      chk({6'h00, gate}, 8'h03);
      // mid-run reset with dimming lowered first
      dim1 = 1'b0;
      dim2 = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({4'h0, flag, gate_sup, gate}, 8'h0C);
      rd(ldc_pkg::ADDR_TARGET_CH1, ldc_pkg::RST_TARGET, 1'b0);
      rd(ldc_pkg::ADDR_RANGE, {6'h00, ldc_pkg::RST_RANGE}, 1'b0);
      rd(ldc_pkg::ADDR_SUPPLY_READ, ldc_pkg::SUPPLY_NOT_READY, 1'b0);
    end
    complete_run();
  end
endmodule : ldc_regs_tb
